// ==== dv/ots_operator.sv ====
// Start switch model of the operator or handling equipment
`timescale 1ns/1ps
module ots_operator (
  input  wire logic clk_sys,
  input  wire logic connected,
  input  wire logic press,
  output logic      start_req
);
  // Pressing with no product on the port does nothing
  always_ff @(posedge clk_sys) begin
    start_req <= press && connected;
  end
endmodule : ots_operator

// ==== dv/ots_properties.sv ====
// Port-level assertions for the occlusion test sequencer
`timescale 1ns/1ps
module ots_properties (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       start_req,
  input wire logic       couple_valve,
  input wire logic       fill_valve,
  input wire logic       dump_valve,
  input wire logic       pass_lamp,
  input wire logic       fail_lamp,
  input wire logic       busy,
  input wire logic [2:0] phase
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  AST_PREADY_AFTER_SETUP: assert property (psel && !penable |=> pready && psel && penable)
    else $error("pready missing after setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_BUSY_PHASE: assert property (busy == (phase != ots_pkg::OTS_IDLE))
    else $error("busy disagrees with phase");
  AST_START: assert property (phase == ots_pkg::OTS_IDLE && $rose(start_req) |=> busy && !pass_lamp && !fail_lamp)
    else $error("start not taken or lamps not cleared");
  AST_COUPLE_HELD: assert property (phase == ots_pkg::OTS_COUPLE |-> couple_valve && !fill_valve)
    else $error("coupling not held in couple delay");
  AST_FILL_OPEN: assert property (phase == ots_pkg::OTS_FILL |-> fill_valve)
    else $error("fill valve shut during fill");
  AST_STAB_CLOSED: assert property (phase == ots_pkg::OTS_STAB |-> !fill_valve && couple_valve)
    else $error("fill valve open in stabilize");
  AST_TEST_UNCOUPLED: assert property (phase == ots_pkg::OTS_TEST |-> !couple_valve)
    else $error("coupling held in test");
  AST_VENT_DUMP: assert property (phase == ots_pkg::OTS_VENT |-> dump_valve && !fill_valve)
    else $error("dump valve shut in vent");
  AST_ONE_LAMP: assert property (!(pass_lamp && fail_lamp))
    else $error("both lamps lit");
  AST_RESULT_HELD: assert property (phase == ots_pkg::OTS_IDLE && $past(phase) == ots_pkg::OTS_IDLE
    |-> $stable(pass_lamp) && $stable(fail_lamp))
    else $error("lamps changed while idle");
  AST_NEXT_EXIT: assert property (phase == ots_pkg::OTS_NEXT |=> phase inside {ots_pkg::OTS_IDLE,
    ots_pkg::OTS_COUPLE, ots_pkg::OTS_FILL})
    else $error("bad exit from next");
  AST_VERDICT_ENDS: assert property ($rose(pass_lamp) || $rose(fail_lamp)
    |-> ##[0:2] phase inside {ots_pkg::OTS_VENT, ots_pkg::OTS_NEXT})
    else $error("verdict without leaving phase");
endmodule : ots_properties

bind ots_sequencer ots_properties ots_properties_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .start_req(start_req), .couple_valve(couple_valve),
  .fill_valve(fill_valve), .dump_valve(dump_valve), .pass_lamp(pass_lamp), .fail_lamp(fail_lamp),
  .busy(busy), .phase(phase));

// ==== dv/tb.sv ====
// Self-checking bench for the occlusion test sequencer
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] NOM  = 16'h03E8;
  localparam logic [15:0] TOL  = 16'h0064;
  localparam logic [15:0] RMIN = 16'h0032;
  localparam logic [15:0] RMAX = 16'h012C;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic [15:0] pressure_in = NOM;
  logic        press = 1'b0;
  logic [31:0] prdata, rd, w;
  logic        pready, pslverr, start_req, se, couple_valve, fill_valve, dump_valve, pass_lamp, fail_lamp, busy;
  logic [2:0]  phase, prev;
  logic [15:0] p_fill = NOM, p_test = NOM;
  logic [15:0] p_low, stb, pf, pt;
  logic [7:0]  mask;
  int          n_errors = 0;
  int          compares = 0;
  int          cyc = 0, tcnt = 0, n_test = 0;

  ots_sequencer #(.TICK_CYC(4)) ots_sequencer_i (.clk_sys(clk_sys), .reset_n(reset_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_req(start_req), .pressure_in(pressure_in), .couple_valve(couple_valve),
    .fill_valve(fill_valve), .dump_valve(dump_valve), .pass_lamp(pass_lamp), .fail_lamp(fail_lamp),
    .busy(busy), .phase(phase));
  ots_operator ots_operator_i (.clk_sys(clk_sys), .connected(1'b1), .press(press), .start_req(start_req));

  always #2.5 clk_sys = ~clk_sys;

  // Pressure follows the phase: loss shows only after p1 is taken, vent bleeds it off
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      n_errors++;
      summarize();
    end
    prev <= phase;
    tcnt <= (phase == ots_pkg::OTS_TEST) ? tcnt + 1 : 0;
    if (busy !== 1'b1) begin
      mask <= 8'h00;
      n_test <= 0;
      p_low <= 16'hFFFF;
    end else if (busy === 1'b1) begin
      mask <= mask | (8'h01 << phase);
      if (phase == ots_pkg::OTS_TEST && prev != ots_pkg::OTS_TEST) n_test <= n_test + 1;
      if (phase == ots_pkg::OTS_VENT && pressure_in < p_low) p_low <= pressure_in;
    end
    if (phase == ots_pkg::OTS_TEST && tcnt >= 4) pressure_in <= p_test;
    else if (phase == ots_pkg::OTS_VENT) pressure_in <= (pressure_in > 16'h0064) ? pressure_in - 16'h0064 : 16'h0000;
    else pressure_in <= p_fill;
  end

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (pready !== 1'b1) n_errors++;
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic expect_run(input logic [31:0] c, input logic [15:0] f, t, vt,
                            output logic ok, output logic [1:0] cs, output logic [7:0] m, output int nt);
    logic [15:0] loss;
    loss = f - t;
    m = 8'h28 | (c[1] ? 8'h02 : 8'h00) | ((c[2] || vt != 16'h0000) ? 8'h80 : 8'h00);
    ok = 1'b1;
    cs = ots_pkg::OTS_CAUSE_NONE;
    nt = 0;
    for (int s = 0; s <= int'(c[11:8]) && ok; s++) begin
      if (!c[3] && f > NOM + TOL) cs = ots_pkg::OTS_CAUSE_HIGH;
      else if (f < NOM - TOL || f > NOM + TOL) cs = ots_pkg::OTS_CAUSE_TOL;
      else begin
        nt++;
        m = m | 8'h40 | ((c[1] && stb != 16'h0000) ? 8'h04 : 8'h00);
        if (c[3] ? (t < RMIN || t > RMAX) : (s == 0 && c[4]) ? loss > RMAX : loss <= RMIN)
          cs = ots_pkg::OTS_CAUSE_REJ;
      end
      ok = (cs == ots_pkg::OTS_CAUSE_NONE);
    end
  endtask : expect_run

  task automatic run(input logic [31:0] c, input logic [15:0] f, t, vt, vol);
    logic       ok;
    logic [1:0] cs;
    logic [7:0] m;
    int         nt;
    int         n;
    expect_run(c, f, t, vt, ok, cs, m, nt);
    p_fill <= f;
    p_test <= t;
    apb(1'b1, ots_pkg::OFF_VENT_T, {16'h0000, vt});
    apb(1'b1, ots_pkg::OFF_VOLUME, {16'h0000, vol});
    // Bit 0 set starts from the bus write instead of the switch
    apb(1'b1, ots_pkg::OFF_CTRL, c);
    press <= !c[0];
    repeat (2) @(posedge clk_sys);
    press <= 1'b0;
    @(posedge clk_sys);
    n = 0;
    while (busy === 1'b1 && n < 5000) begin
      n++;
      @(posedge clk_sys);
    end
    chk("phase", 32'(phase), 32'h0000_0000);
    chk("lamps", 32'({pass_lamp, fail_lamp}), 32'({ok, !ok}));
    chk("phases", 32'(mask), 32'(m));
    chk("tests", 32'(n_test), 32'(nt));
    if (c[2] && vt == 16'h0000) chk("vent floor", 32'(p_low < ots_pkg::VENT_AUTO_THR), 32'h0000_0001);
    apb(1'b0, ots_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status", 32'({rd[9:8], rd[6:5]}), 32'({cs, !ok, ok}));
    if (!c[3] && (cs == ots_pkg::OTS_CAUSE_NONE || cs == ots_pkg::OTS_CAUSE_REJ)) begin
      chk("ccm", 32'(rd[7]), 32'(vol != 16'h0000));
      apb(1'b0, ots_pkg::OFF_RESULT, 32'h0000_0000);
      chk("result", rd, (vol == 16'h0000) ? 32'(f - t) : 32'(f - t) * 32'(vol));
    end
  endtask : run

  initial begin
    w = $urandom(32'h585c_0863);
    stb = 16'h0001;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    for (int a = 4; a <= 48; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000);
      chk("reset value", rd, ots_pkg::RST_WORD);
      if (a <= 40) begin
        w = $urandom;
        apb(1'b1, 8'(a), w);
        apb(1'b0, 8'(a), 32'h0000_0000);
        chk("readback", rd, {16'h0000, w[15:0]});
      end
    end
    apb(1'b1, ots_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    apb(1'b0, ots_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status read only", rd, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("unmapped", {rd[30:0], se}, 32'h0000_0001);
    apb(1'b1, ots_pkg::OFF_COUPLE_T, 32'h0000_0001);
    apb(1'b1, ots_pkg::OFF_FILL_T, 32'h0000_0003);
    apb(1'b1, ots_pkg::OFF_STAB_T, 32'h0000_0001);
    apb(1'b1, ots_pkg::OFF_TEST_T, 32'h0000_0003);
    apb(1'b1, ots_pkg::OFF_TEST_P, {16'h0000, NOM});
    apb(1'b1, ots_pkg::OFF_PERR, {16'h0000, TOL});
    apb(1'b1, ots_pkg::OFF_REJ_MIN, {16'h0000, RMIN});
    apb(1'b1, ots_pkg::OFF_REJ_MAX, {16'h0000, RMAX});
    run(32'h0000_0000, NOM, NOM - 16'h00C8, 16'h0000, 16'h0000);
    run(32'h0000_0000, NOM, NOM - RMIN, 16'h0001, 16'h0005);
    run(32'h0000_0006, NOM + TOL + 16'h0001, NOM, 16'h0000, 16'h0000);
    run(32'h0000_0002, NOM - TOL - 16'h0001, NOM, 16'h0001, 16'h0000);
    run(32'h0000_0008, NOM, 16'h00C8, 16'h0000, 16'h0000);
    run(32'h0000_0008, NOM + TOL + 16'h0001, RMAX + 16'h0001, 16'h0000, 16'h0000);
    run(32'h0000_0116, NOM, NOM - 16'h00C8, 16'h0000, 16'h0002);
    run(32'h0000_0210, NOM, NOM - RMAX - 16'h0001, 16'h0001, 16'h0000);
    stb = 16'h0000;
    apb(1'b1, ots_pkg::OFF_STAB_T, 32'h0000_0000);
    run(32'h0000_0002, NOM, NOM - 16'h0064, 16'h0000, 16'h0000);
    stb = 16'h0001;
    apb(1'b1, ots_pkg::OFF_STAB_T, 32'h0000_0001);
    for (int i = 0; i < 12; i++) begin
      w = $urandom;
      pf = NOM - 16'h0096 + 16'($urandom % 300);
      pt = pf - 16'($urandom % 400);
      run(w & 32'h0000_0317, pf, pt, 16'(w[12]), 16'(w[14:13]));
    end
    summarize();
  end
endmodule : tb

// ==== verilog/ots_phase_timer.sv ====
// Phase down-counter with its own millisecond tick divider
`timescale 1ns/1ps
module ots_phase_timer #(
  parameter int TICK_CYC = ots_pkg::TICK_CYC_DFLT
) (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  ots_tmr_if.tmr    t
);

  typedef struct packed {
    logic [ots_pkg::DIV_W-1:0] div;
    logic [ots_pkg::PW-1:0]    cnt;
    logic                      run;
    logic                      done;
  } ots_tmr_state_t;

  localparam logic [ots_pkg::DIV_W-1:0] DIV_LAST = ots_pkg::DIV_W'(TICK_CYC - 1);

  ots_tmr_state_t s_reg;
  ots_tmr_state_t s_next;
  logic           tick;

  assign t.done = s_reg.done;

  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    tick        = (s_reg.div == '0);
    s_next.div  = tick ? DIV_LAST : s_reg.div - 1'b1;
    if (t.ld) begin
      // Reload restarts the tick so a phase never runs short
      s_next.cnt = t.ld_val;
      s_next.run = 1'b1;
      s_next.div = DIV_LAST;
    end else if (s_reg.run) begin
      if (s_reg.cnt == '0) begin
        s_next.done = 1'b1;
        s_next.run  = 1'b0;
      end else if (tick) begin
        s_next.cnt = s_reg.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ots_phase_timer

// ==== verilog/ots_pkg.sv ====
// Package with constants, register map and types of the occlusion test sequencer
package ots_pkg;

  // Timebase: one phase-timer tick per millisecond at the 200 MHz system clock
  localparam int          CLK_FREQ_MHZ   = 200;
  localparam int          TICK_TIME_US   = 1000;
  localparam int          TICK_CYC_DFLT  = TICK_TIME_US * CLK_FREQ_MHZ;
  localparam int          DIV_W          = 32;

  // Data widths
  localparam int          PW             = 16;
  localparam int          LINK_W         = 4;

  // Pressure scale is 1 mpsig per LSB; auto vent closes below 0.5 psig
  localparam logic [15:0] VENT_AUTO_THR  = 16'h01F4;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_COUPLE_T   = 8'h04;
  localparam logic [7:0]  OFF_FILL_T     = 8'h08;
  localparam logic [7:0]  OFF_STAB_T     = 8'h0C;
  localparam logic [7:0]  OFF_TEST_T     = 8'h10;
  localparam logic [7:0]  OFF_VENT_T     = 8'h14;
  localparam logic [7:0]  OFF_TEST_P     = 8'h18;
  localparam logic [7:0]  OFF_PERR       = 8'h1C;
  localparam logic [7:0]  OFF_REJ_MIN    = 8'h20;
  localparam logic [7:0]  OFF_REJ_MAX    = 8'h24;
  localparam logic [7:0]  OFF_VOLUME     = 8'h28;
  localparam logic [7:0]  OFF_STATUS     = 8'h2C;
  localparam logic [7:0]  OFF_RESULT     = 8'h30;

  // Control register fields
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_SEALED    = 1;
  localparam int          CTRL_VAUTO     = 2;
  localparam int          CTRL_BP        = 3;
  localparam int          CTRL_DECAY1    = 4;
  localparam int          CTRL_LINK_LO   = 8;

  // Status register fields
  localparam int          STS_PHASE_LO   = 0;
  localparam int          STS_BUSY       = 4;
  localparam int          STS_PASS       = 5;
  localparam int          STS_FAIL       = 6;
  localparam int          STS_CCM        = 7;
  localparam int          STS_CAUSE_LO   = 8;
  localparam int          STS_STEP_LO    = 12;

  // Reset values
  localparam logic [15:0] RST_TIME       = 16'h0000;
  localparam logic [31:0] RST_WORD       = 32'h0000_0000;

  // Sequencer phases, Gray coded along the usual path
  typedef enum logic [2:0] {
    OTS_IDLE   = 3'h0,
    OTS_COUPLE = 3'h1,
    OTS_FILL   = 3'h3,
    OTS_STAB   = 3'h2,
    OTS_TEST   = 3'h6,
    OTS_VENT   = 3'h7,
    OTS_NEXT   = 3'h5
  } ots_phase_t;

  // Why the last test failed
  typedef enum logic [1:0] {
    OTS_CAUSE_NONE = 2'h0,
    OTS_CAUSE_HIGH = 2'h1,
    OTS_CAUSE_TOL  = 2'h2,
    OTS_CAUSE_REJ  = 2'h3
  } ots_cause_t;

endpackage : ots_pkg

// ==== verilog/ots_sequencer.sv ====
// Occlusion test phase sequencer with APB register slave
//
// Notes on behaviour
// - Sealed mode runs couple delay, coupling valve held until release.
// - After couple, fill valve opens; fill end checks pressure tolerance else fail.
// - Fill valve closes at fill end except in back-pressure mode; zero stabilize time skips stabilize.
// - Test phase entered only within pressure tolerance, otherwise fail.
// - Sealed mode drops coupling at test start so the product vents.
// - Pass when loss exceeds reject minimum, fail when loss is at or below.
// - Result and lamps held until next test starts, then cleared.
// - Vent after test when vent time nonzero or auto; zero skips venting.
// - Linked program starts only if every test so far passed.
// - After the last linked test the sequencer returns to idle.
// - Unsealed mode skips couple and stabilize, fill opens at once.
// - Outside back-pressure mode, pressure above upper tolerance during fill fails the test.
// - Result is pressure loss for zero volume, else volume-scaled flow.
// - Back-pressure mode passes only with end pressure within reject limits.
// - A decay program may run ahead of the occlusion program.
// - Auto vent holds dump valve open until pressure below 0.5 psig.
`timescale 1ns/1ps
module ots_sequencer #(
  parameter int TICK_CYC = ots_pkg::TICK_CYC_DFLT
) (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        start_req,
  input  wire logic [15:0] pressure_in,
  output logic             couple_valve,
  output logic             fill_valve,
  output logic             dump_valve,
  output logic             pass_lamp,
  output logic             fail_lamp,
  output logic             busy,
  output logic      [2:0]  phase
);

  typedef struct packed {
    ots_pkg::ots_phase_t              st;
    ots_pkg::ots_cause_t              cause;
    logic [ots_pkg::LINK_W-1:0]       step;
    logic                             chain_ok;
    logic [ots_pkg::PW-1:0]           p1;
    logic [31:0]                      result;
    logic                             ccm;
    logic                             sealed;
    logic                             vauto;
    logic                             bp;
    logic                             decay1;
    logic [ots_pkg::LINK_W-1:0]       link;
    logic [ots_pkg::PW-1:0]           t_couple;
    logic [ots_pkg::PW-1:0]           t_fill;
    logic [ots_pkg::PW-1:0]           t_stab;
    logic [ots_pkg::PW-1:0]           t_test;
    logic [ots_pkg::PW-1:0]           t_vent;
    logic [ots_pkg::PW-1:0]           nom;
    logic [ots_pkg::PW-1:0]           tol;
    logic [ots_pkg::PW-1:0]           rmin;
    logic [ots_pkg::PW-1:0]           rmax;
    logic [ots_pkg::PW-1:0]           vol;
    logic                             start_d;
    logic                             couple;
    logic                             fill;
    logic                             dump;
    logic                             pass;
    logic                             fail;
    logic [31:0]                      prdata;
    logic                             pready;
    logic                             pslverr;
    logic                             ld;
    logic [ots_pkg::PW-1:0]           ld_val;
    logic                             busy;
  } ots_seq_state_t;

  ots_seq_state_t s_reg;
  ots_seq_state_t s_next;
  ots_tmr_if      tif ();

  logic        tdone;
  logic        start_ev;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic [31:0] rd_word;
  logic [15:0] loss;
  logic        good;
  logic        end_ok;

  // Pressure within nominal +/- tolerance, widened to avoid wrap
  function automatic logic in_tol(input logic [15:0] p, input logic [15:0] nom, input logic [15:0] tol);
    in_tol = ({1'b0, p} + {1'b0, tol} >= {1'b0, nom}) && ({1'b0, p} <= {1'b0, nom} + {1'b0, tol});
  endfunction : in_tol

  function automatic logic above_tol(input logic [15:0] p, input logic [15:0] nom, input logic [15:0] tol);
    above_tol = {1'b0, p} > {1'b0, nom} + {1'b0, tol};
  endfunction : above_tol

  // Register read and address decode
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      ots_pkg::OFF_CTRL, ots_pkg::OFF_COUPLE_T, ots_pkg::OFF_FILL_T, ots_pkg::OFF_STAB_T,
      ots_pkg::OFF_TEST_T, ots_pkg::OFF_VENT_T, ots_pkg::OFF_TEST_P, ots_pkg::OFF_PERR,
      ots_pkg::OFF_REJ_MIN, ots_pkg::OFF_REJ_MAX, ots_pkg::OFF_VOLUME, ots_pkg::OFF_STATUS,
      ots_pkg::OFF_RESULT: is_mapped = 1'b1;
      default:             is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign tif.ld     = s_reg.ld;
  assign tif.ld_val = s_reg.ld_val;
  // A done seen while a reload is in flight belongs to an abandoned phase
  assign tdone      = tif.done && !s_reg.ld;

  assign couple_valve = s_reg.couple;
  assign fill_valve   = s_reg.fill;
  assign dump_valve   = s_reg.dump;
  assign pass_lamp    = s_reg.pass;
  assign fail_lamp    = s_reg.fail;
  assign busy         = s_reg.busy;
  assign phase        = s_reg.st;
  assign prdata       = s_reg.prdata;
  assign pready       = s_reg.pready;
  assign pslverr      = s_reg.pslverr;

  ots_phase_timer #(
    .TICK_CYC (TICK_CYC)
  ) u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .t       (tif.tmr)
  );

  always_comb begin
    rd_word = '0;
    case (paddr)
      ots_pkg::OFF_CTRL: begin
        rd_word[ots_pkg::CTRL_SEALED] = s_reg.sealed;
        rd_word[ots_pkg::CTRL_VAUTO]  = s_reg.vauto;
        rd_word[ots_pkg::CTRL_BP]     = s_reg.bp;
        rd_word[ots_pkg::CTRL_DECAY1] = s_reg.decay1;
        rd_word[ots_pkg::CTRL_LINK_LO +: ots_pkg::LINK_W] = s_reg.link;
      end
      ots_pkg::OFF_COUPLE_T: rd_word[15:0] = s_reg.t_couple;
      ots_pkg::OFF_FILL_T:   rd_word[15:0] = s_reg.t_fill;
      ots_pkg::OFF_STAB_T:   rd_word[15:0] = s_reg.t_stab;
      ots_pkg::OFF_TEST_T:   rd_word[15:0] = s_reg.t_test;
      ots_pkg::OFF_VENT_T:   rd_word[15:0] = s_reg.t_vent;
      ots_pkg::OFF_TEST_P:   rd_word[15:0] = s_reg.nom;
      ots_pkg::OFF_PERR:     rd_word[15:0] = s_reg.tol;
      ots_pkg::OFF_REJ_MIN:  rd_word[15:0] = s_reg.rmin;
      ots_pkg::OFF_REJ_MAX:  rd_word[15:0] = s_reg.rmax;
      ots_pkg::OFF_VOLUME:   rd_word[15:0] = s_reg.vol;
      ots_pkg::OFF_STATUS: begin
        rd_word[ots_pkg::STS_PHASE_LO +: 3] = s_reg.st;
        rd_word[ots_pkg::STS_BUSY]          = (s_reg.st != ots_pkg::OTS_IDLE);
        rd_word[ots_pkg::STS_PASS]          = s_reg.pass;
        rd_word[ots_pkg::STS_FAIL]          = s_reg.fail;
        rd_word[ots_pkg::STS_CCM]           = s_reg.ccm;
        rd_word[ots_pkg::STS_CAUSE_LO +: 2] = s_reg.cause;
        rd_word[ots_pkg::STS_STEP_LO +: ots_pkg::LINK_W] = s_reg.step;
      end
      ots_pkg::OFF_RESULT:   rd_word = s_reg.result;
      default:               rd_word = '0;
    endcase
  end

  always_comb begin
    s_next         = s_reg;
    s_next.ld      = 1'b0;
    s_next.start_d = start_req;
    hit            = is_mapped(paddr);
    wr_en          = psel && penable && s_reg.pready && pwrite && hit;
    rd_en          = psel && !penable;
    // Pressure loss from the test-start sample, floored at zero
    loss           = (s_reg.p1 > pressure_in) ? s_reg.p1 - pressure_in : '0;
    start_ev       = (start_req && !s_reg.start_d) ||
                     (wr_en && paddr == ots_pkg::OFF_CTRL && pwdata[ots_pkg::CTRL_START]);
    // Pass decision per program kind
    if (s_reg.bp) begin
      good = (pressure_in >= s_reg.rmin) && (pressure_in <= s_reg.rmax);
    end else if (s_reg.decay1 && s_reg.step == '0) begin
      good = (loss <= s_reg.rmax);
    end else begin
      good = (loss > s_reg.rmin);
    end
    end_ok = 1'b0;

    // APB slave: no wait states, answer registered
    s_next.pready  = rd_en;
    s_next.pslverr = rd_en && !hit;
    if (rd_en) begin
      s_next.prdata = rd_word;
    end
    if (wr_en) begin
      case (paddr)
        ots_pkg::OFF_CTRL: begin
          s_next.sealed = pwdata[ots_pkg::CTRL_SEALED];
          s_next.vauto  = pwdata[ots_pkg::CTRL_VAUTO];
          s_next.bp     = pwdata[ots_pkg::CTRL_BP];
          s_next.decay1 = pwdata[ots_pkg::CTRL_DECAY1];
          s_next.link   = pwdata[ots_pkg::CTRL_LINK_LO +: ots_pkg::LINK_W];
        end
        ots_pkg::OFF_COUPLE_T: s_next.t_couple = pwdata[15:0];
        ots_pkg::OFF_FILL_T:   s_next.t_fill   = pwdata[15:0];
        ots_pkg::OFF_STAB_T:   s_next.t_stab   = pwdata[15:0];
        ots_pkg::OFF_TEST_T:   s_next.t_test   = pwdata[15:0];
        ots_pkg::OFF_VENT_T:   s_next.t_vent   = pwdata[15:0];
        ots_pkg::OFF_TEST_P:   s_next.nom      = pwdata[15:0];
        ots_pkg::OFF_PERR:     s_next.tol      = pwdata[15:0];
        ots_pkg::OFF_REJ_MIN:  s_next.rmin     = pwdata[15:0];
        ots_pkg::OFF_REJ_MAX:  s_next.rmax     = pwdata[15:0];
        ots_pkg::OFF_VOLUME:   s_next.vol      = pwdata[15:0];
        default: ;
      endcase
    end

    case (s_reg.st)
      ots_pkg::OTS_IDLE: begin
        if (start_ev) begin
          s_next.step     = '0;
          s_next.chain_ok = 1'b1;
          end_ok          = 1'b1;
        end
      end
      ots_pkg::OTS_COUPLE: begin
        if (tdone) begin
          s_next.st     = ots_pkg::OTS_FILL;
          s_next.fill   = 1'b1;
          s_next.ld     = 1'b1;
          s_next.ld_val = s_reg.t_fill;
        end
      end
      ots_pkg::OTS_FILL: begin
        if (!s_reg.bp && above_tol(pressure_in, s_reg.nom, s_reg.tol)) begin
          // Blocked path drives pressure up during fill
          s_next.cause = ots_pkg::OTS_CAUSE_HIGH;
          s_next.fail  = 1'b1;
        end else if (tdone) begin
          // Back-pressure keeps supply open through the test
          s_next.fill = s_reg.bp;
          if (!in_tol(pressure_in, s_reg.nom, s_reg.tol)) begin
            s_next.cause = ots_pkg::OTS_CAUSE_TOL;
            s_next.fail  = 1'b1;
          end else if (s_reg.sealed && s_reg.t_stab != '0) begin
            s_next.st     = ots_pkg::OTS_STAB;
            s_next.ld     = 1'b1;
            s_next.ld_val = s_reg.t_stab;
          end else begin
            s_next.st     = ots_pkg::OTS_TEST;
            s_next.p1     = pressure_in;
            s_next.couple = 1'b0;
            s_next.ld     = 1'b1;
            s_next.ld_val = s_reg.t_test;
          end
        end
      end
      ots_pkg::OTS_STAB: begin
        if (tdone) begin
          if (in_tol(pressure_in, s_reg.nom, s_reg.tol)) begin
            s_next.st     = ots_pkg::OTS_TEST;
            s_next.p1     = pressure_in;
            s_next.couple = 1'b0;
            s_next.ld     = 1'b1;
            s_next.ld_val = s_reg.t_test;
          end else begin
            s_next.cause = ots_pkg::OTS_CAUSE_TOL;
            s_next.fail  = 1'b1;
          end
        end
      end
      ots_pkg::OTS_TEST: begin
        if (tdone) begin
          s_next.fill   = 1'b0;
          s_next.pass   = good;
          s_next.fail   = !good;
          s_next.cause  = good ? ots_pkg::OTS_CAUSE_NONE : ots_pkg::OTS_CAUSE_REJ;
          s_next.ccm    = (s_reg.vol != '0);
          s_next.result = (s_reg.vol == '0) ? {16'h0000, loss} : loss * s_reg.vol;
        end
      end
      ots_pkg::OTS_VENT: begin
        if (s_reg.vauto) begin
          if (pressure_in < ots_pkg::VENT_AUTO_THR) begin
            s_next.dump = 1'b0;
            s_next.st   = ots_pkg::OTS_NEXT;
          end
        end else if (tdone) begin
          s_next.dump = 1'b0;
          s_next.st   = ots_pkg::OTS_NEXT;
        end
      end
      ots_pkg::OTS_NEXT: begin
        if (s_reg.chain_ok && s_reg.step != s_reg.link) begin
          s_next.step = s_reg.step + 1'b1;
          end_ok      = 1'b1;
        end else begin
          s_next.st = ots_pkg::OTS_IDLE;
        end
      end
      default: begin
        s_next.st = ots_pkg::OTS_IDLE;
      end
    endcase

    // A fail from any phase, or the test result, closes the step
    if (s_next.fail && !s_reg.fail || s_reg.st == ots_pkg::OTS_TEST && tdone) begin
      s_next.fill     = 1'b0;
      s_next.couple   = 1'b0;
      s_next.chain_ok = s_reg.chain_ok && s_next.pass;
      if (s_reg.vauto) begin
        s_next.st   = ots_pkg::OTS_VENT;
        s_next.dump = 1'b1;
      end else if (s_reg.t_vent != '0) begin
        s_next.st     = ots_pkg::OTS_VENT;
        s_next.dump   = 1'b1;
        s_next.ld     = 1'b1;
        s_next.ld_val = s_reg.t_vent;
      end else begin
        s_next.st = ots_pkg::OTS_NEXT;
      end
    end

    // Start of a test, fresh or linked
    if (end_ok) begin
      s_next.pass   = 1'b0;
      s_next.fail   = 1'b0;
      s_next.cause  = ots_pkg::OTS_CAUSE_NONE;
      s_next.result = ots_pkg::RST_WORD;
      s_next.ccm    = 1'b0;
      s_next.ld     = 1'b1;
      if (s_next.sealed) begin // Mode written along with a bus start applies now
        s_next.st     = ots_pkg::OTS_COUPLE;
        s_next.couple = 1'b1;
        s_next.ld_val = s_reg.t_couple;
      end else begin
        s_next.st     = ots_pkg::OTS_FILL;
        s_next.fill   = 1'b1;
        s_next.ld_val = s_reg.t_fill;
      end
    end
    s_next.busy = (s_next.st != ots_pkg::OTS_IDLE);
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_reg    <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

endmodule : ots_sequencer

// ==== verilog/ots_tmr_if.sv ====
// Interface between the sequencer and its phase timer
`timescale 1ns/1ps
interface ots_tmr_if;
  logic        ld;
  logic [15:0] ld_val;
  logic        done;
  modport ctl (output ld, output ld_val, input done);
  modport tmr (input ld, input ld_val, output done);
endinterface : ots_tmr_if
